//--- src/mpr_pkg.sv
// constants for the module power and reset controller
package mpr_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	// time base: one tick per millisecond
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYC = TICK_NS / 25;
	localparam logic [15:0] TICK_CYC_M1 = 16'(TICK_CYC - 1);
	// reset input must stay low at least this long
	localparam int unsigned RST_MIN_MS = 500;
	// power request must stay high more than this long
	localparam int unsigned PWR_ON_MS = 1200;
	// length of the module reset pulse issued internally
	localparam int unsigned RST_PULSE_MS = 10;
	localparam logic [11:0] RST_MIN_TICKS = 12'(RST_MIN_MS);
	localparam logic [11:0] PWR_ON_TICKS = 12'(PWR_ON_MS + 1);
	localparam logic [11:0] RST_PULSE_TICKS = 12'(RST_PULSE_MS);
	localparam logic [11:0] CNT_MAX = 12'hfff;
endpackage : mpr_pkg

//--- src/mpr_hold_timer.sv
// saturating tick counter measuring how long a level has been held
`timescale 1ns/1ps
module mpr_hold_timer
	import mpr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic level,
	output logic [11:0] held_r
);
	// count ticks while level holds, clear otherwise
	always_ff @(posedge sys_clk) begin
		if (!rst_b || !level) begin
			held_r <= 12'h000;
		end else if (tick && held_r != CNT_MAX) begin
			held_r <= held_r + 12'h001;
		end
	end
endmodule : mpr_hold_timer

//--- src/mpr_ctrl.sv
// power on/off, reset sequencing and rf status indicator for the module
//
// What this block and its host must do
// RQ1 - host holds reset low 0.5 to 3 s
// RQ2 - reset low 0.5 s then release resets
// RQ3 - power input level-sensitive, low powers off
// RQ4 - power request high over 1.2 s powers on
// RQ5 - host waits 40 ms after supply
// RQ6 - power input pulled up internally
// RQ7 - reset input pulled up internally
// RQ8 - host waits 20 s between resets
// RQ9 - software reset command resets module too
// RQ10 - indicator low when rf enabled, else high; stays high while the module is off or in reset
// RQ11 - host gpio should reset low
// RQ12 - indicator is open-drain, pulls low only
// RQ13 - inputs synchronised, short pulses ignored; a power low, software reset or rf enable acts at once
`timescale 1ns/1ps
module mpr_ctrl
	import mpr_pkg::*;
#(
	// clock cycles per time base tick; a short value is only for quick runs
	parameter int unsigned TICK_DIV = TICK_CYC
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic card_power_control_in,
	input wire logic card_power_control_oe,
	input wire logic module_reset_in,
	input wire logic module_reset_oe,
	input wire logic software_reset_command,
	input wire logic rf_enabled,
	output logic module_power_en_r,
	output logic module_reset_b_r,
	output logic rf_status_indicator_out_r,
	output logic rf_status_indicator_oe_r
);
	typedef enum logic [1:0] {MPR_OFF, MPR_ON, MPR_RESET} mpr_state_t;

	// positions of the raw inputs in the synchroniser vector
	localparam int unsigned SYN_PWR_IN = 0;
	localparam int unsigned SYN_PWR_OE = 1;
	localparam int unsigned SYN_RST_IN = 2;
	localparam int unsigned SYN_RST_OE = 3;
	localparam int unsigned SYN_SWR = 4;
	localparam int unsigned SYN_RFE = 5;
	// reset image: power pin driven low, reset pin driven high, requests idle
	// so that nothing looks like a request in the two cycles after reset
	localparam logic [5:0] SYN_RST_VAL = 6'h0e;
	// last count of the tick divider
	localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

	mpr_state_t state_r;
	logic [5:0] raw_in;
	logic [5:0] syn_a_r;
	logic [5:0] syn_b_r;
	logic [15:0] div_r;
	logic tick_r;
	logic rst_low_r;
	logic rst_armed_r;
	logic [11:0] pwr_held;
	logic [11:0] rst_held;
	logic [11:0] pulse_r;
	logic pwr_level;
	logic rst_level;

	// resolve a pin with an internal pull-up from its value and drive flag
	function automatic logic pulled_up(input logic oe, input logic val);
		pulled_up = oe ? val : 1'b1;
	endfunction : pulled_up

	// gather the asynchronous inputs, value and drive flag kept apart
	assign raw_in = {rf_enabled, software_reset_command, module_reset_oe, module_reset_in,
		card_power_control_oe, card_power_control_in};

	// RQ13 two-stage sync
	// no logic touches a pin before both flops; only the second stage is read
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			syn_a_r <= SYN_RST_VAL;
			syn_b_r <= SYN_RST_VAL;
		end else begin
			syn_a_r <= raw_in;
			syn_b_r <= syn_a_r;
		end
	end

	// RQ6 pull-up
	// an undriven power input reads as the power-on request
	assign pwr_level = pulled_up(syn_b_r[SYN_PWR_OE], syn_b_r[SYN_PWR_IN]);
	// RQ7 pull-up
	// an undriven reset input never reads as low
	assign rst_level = pulled_up(syn_b_r[SYN_RST_OE], syn_b_r[SYN_RST_IN]);

	// millisecond tick divider
	// free running, so a hold time is measured to within one tick
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			div_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (div_r == TICK_LAST) begin
			div_r <= 16'h0000;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 16'h0001;
			tick_r <= 1'b0;
		end
	end

	// RQ13 hold counters
	mpr_hold_timer u_pwr_timer (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick(tick_r),
		.level(pwr_level),
		.held_r(pwr_held)
	);
	mpr_hold_timer u_rst_timer (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick(tick_r),
		.level(rst_low_r),
		.held_r(rst_held)
	);

	// reset input low level and qualification flag
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rst_low_r <= 1'b0;
			rst_armed_r <= 1'b0;
		end else begin
			rst_low_r <= ~rst_level;
			// RQ2 qualify long low
			if (rst_low_r && rst_held >= RST_MIN_TICKS) begin
				rst_armed_r <= 1'b1;
			end else if (!rst_low_r) begin
				rst_armed_r <= 1'b0;
			end
		end
	end

	// power and reset state machine
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_r <= MPR_OFF;
			pulse_r <= 12'h000;
		end else begin
			case (state_r)
				MPR_OFF: begin
					// RQ4 long high powers
					if (pwr_level && pwr_held >= PWR_ON_TICKS) begin
						state_r <= MPR_ON;
					end
				end
				MPR_ON: begin
					// RQ3 low powers off
					if (!pwr_level) begin
						state_r <= MPR_OFF;
					// RQ2 reset on release
					// a reset input still held low keeps the module running
					end else if (rst_armed_r && !rst_low_r) begin
						state_r <= MPR_RESET;
						pulse_r <= 12'h000;
					// RQ9 software reset
					end else if (syn_b_r[SYN_SWR]) begin
						state_r <= MPR_RESET;
						pulse_r <= 12'h000;
					end
				end
				MPR_RESET: begin
					// power loss beats the reset pulse; a held command extends it
					if (!pwr_level) begin
						state_r <= MPR_OFF;
					end else if (pulse_r >= RST_PULSE_TICKS && !syn_b_r[SYN_SWR]) begin
						state_r <= MPR_ON;
					end else if (tick_r && pulse_r != CNT_MAX) begin
						pulse_r <= pulse_r + 12'h001;
					end
				end
				default: begin
					state_r <= MPR_OFF;
				end
			endcase
		end
	end

	// RQ3 RQ4 powered unless off
	// power stays on through the internal reset pulse
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			module_power_en_r <= 1'b0;
		end else begin
			module_power_en_r <= (state_r != MPR_OFF);
		end
	end

	// RQ2 RQ9 run only when on
	// the module is held in reset both while off and during the pulse
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			module_reset_b_r <= 1'b0;
		end else begin
			module_reset_b_r <= (state_r == MPR_ON);
		end
	end

	// RQ12 open-drain data
	// the data side never drives high; the pad only pulls low or lets go
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rf_status_indicator_out_r <= 1'b0;
		end else begin
			rf_status_indicator_out_r <= 1'b0; // open drain: only ever low
		end
	end

	// RQ10 RQ12 lit when enabled
	// the lamp stays dark while the module is off or in reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rf_status_indicator_oe_r <= 1'b0;
		end else begin
			rf_status_indicator_oe_r <= syn_b_r[SYN_RFE] && (state_r == MPR_ON);
		end
	end
endmodule : mpr_ctrl

//--- tb/mpr_ctrl_properties.sv
// port assertions for the power and reset controller
`timescale 1ns/1ps
module mpr_chk (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic card_power_control_in,
	input wire logic card_power_control_oe,
	input wire logic module_reset_in,
	input wire logic module_reset_oe,
	input wire logic software_reset_command,
	input wire logic rf_enabled,
	input wire logic module_power_en_r,
	input wire logic module_reset_b_r,
	input wire logic rf_status_indicator_out_r,
	input wire logic rf_status_indicator_oe_r
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// power pin driven low by the host
	wire pin_lo = card_power_control_oe && !card_power_control_in;
	// reset pin driven low by the host
	wire rst_lo = module_reset_oe && !module_reset_in;
	sequence pin_lo_s;
		pin_lo [*8];
	endsequence
	od_data_low_a: assert property (!rf_status_indicator_out_r) else $error("od data high");
	lit_gate_a: assert property (rf_status_indicator_oe_r |-> module_power_en_r) else $error("lit off");
	lit_on_a: assert property ((module_reset_b_r && rf_enabled) [*6] |-> rf_status_indicator_oe_r)
		else $error("not lit");
	pwr_off_a: assert property (pin_lo_s |-> !module_power_en_r) else $error("still on");
	pwr_rise_a: assert property ($rose(module_power_en_r) |-> !$past(pin_lo, 8)) else $error("bad on");
	off_cause_a: assert property ($fell(module_power_en_r) |-> $past(pin_lo, 3)) else $error("bad off");
	rst_pwr_a: assert property (module_reset_b_r |-> module_power_en_r) else $error("run unpowered");
	rst_cause_a: assert property ($fell(module_reset_b_r) && module_power_en_r |->
		$past(software_reset_command, 3) || $past(rst_lo, 8)) else $error("bad reset");
endmodule : mpr_chk
bind mpr_ctrl mpr_chk i_chk (.*);

//--- tb/mpr_host.sv
// host model driving the power and reset pins
`timescale 1ns/1ps
module mpr_host (
	input wire logic sys_clk,
	input wire logic pwr_req,
	input wire logic rst_req,
	input wire logic float_pins,
	output logic pwr_in,
	output logic pwr_oe,
	output logic rst_in,
	output logic rst_oe
);
	initial begin
		pwr_in = 1'b0;
		pwr_oe = 1'b1;
		rst_in = 1'b1;
		rst_oe = 1'b1;
	end
	// drive pins, pull-up level when released
	always @(posedge sys_clk) begin
		pwr_oe <= !float_pins;
		rst_oe <= !float_pins;
		pwr_in <= float_pins || pwr_req;
		rst_in <= float_pins || !rst_req;
	end
endmodule : mpr_host

//--- tb/module_power_reset_control_tb_top.sv
// self-checking bench for the power and reset controller
`timescale 1ns/1ps
module module_power_reset_control_tb_top;
	logic sys_clk, rst_b, pwr_req, rst_req, float_pins, sw_cmd, rf_en;
	wire pwr_in, pwr_oe, rst_in, rst_oe, pwr_en, run_b, ind_out, ind_oe;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	// shortened time base so power-on and resets fit the run
	localparam int unsigned TB_TICK = 8;
	mpr_host i_host (.sys_clk(sys_clk), .pwr_req(pwr_req), .rst_req(rst_req), .float_pins(float_pins),
		.pwr_in(pwr_in), .pwr_oe(pwr_oe), .rst_in(rst_in), .rst_oe(rst_oe));
	mpr_ctrl #(.TICK_DIV(TB_TICK)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .card_power_control_in(pwr_in),
		.card_power_control_oe(pwr_oe), .module_reset_in(rst_in), .module_reset_oe(rst_oe),
		.software_reset_command(sw_cmd), .rf_enabled(rf_en), .module_power_en_r(pwr_en),
		.module_reset_b_r(run_b), .rf_status_indicator_out_r(ind_out), .rf_status_indicator_oe_r(ind_oe));
	// 40 mhz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task close_out;
		$display("errors %0d checks %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			close_out;
		end
	end
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : step
	task chk(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t output mismatch", $time);
		end
	endtask : chk
	// every output idle while the module stays off
	task chk_off;
		chk(pwr_en, 1'b0);
		chk(run_b, 1'b0);
		chk(ind_out, 1'b0);
		chk(ind_oe, 1'b0);
	endtask : chk_off
	// power request below the threshold, rf enabled: stays off and dark
	task t_short_power;
		rf_en = 1'b1;
		pwr_req = 1'b1;
		step((mpr_pkg::PWR_ON_MS - 100) * TB_TICK);
		chk_off;
		pwr_req = 1'b0;
		step(10);
		chk_off;
	endtask : t_short_power
	// long power request powers on; indicator follows rf enable
	task t_power_on;
		pwr_req = 1'b1;
		step((mpr_pkg::PWR_ON_MS + 10) * TB_TICK);
		chk(pwr_en, 1'b1);
		chk(run_b, 1'b1);
		chk(ind_out, 1'b0);
		chk(ind_oe, 1'b1);
		rf_en = 1'b0;
		step(10);
		chk(ind_oe, 1'b0);
		rf_en = 1'b1;
		step(10);
		chk(ind_oe, 1'b1);
	endtask : t_power_on
	// released pins read as pulled up: module keeps running
	task t_float_on;
		float_pins = 1'b1;
		step(50);
		chk(pwr_en, 1'b1);
		chk(run_b, 1'b1);
		float_pins = 1'b0;
		step(10);
	endtask : t_float_on
	// long reset low resets on release; short one is ignored
	task t_pin_reset;
		rst_req = 1'b1;
		step((mpr_pkg::RST_MIN_MS + 10) * TB_TICK);
		chk(run_b, 1'b1);
		rst_req = 1'b0;
		step(10);
		chk(run_b, 1'b0);
		chk(pwr_en, 1'b1);
		step((mpr_pkg::RST_PULSE_MS + 4) * TB_TICK);
		chk(run_b, 1'b1);
		step(20 * TB_TICK);
		rst_req = 1'b1;
		step((mpr_pkg::RST_MIN_MS - 100) * TB_TICK);
		rst_req = 1'b0;
		step(10);
		chk(run_b, 1'b1);
	endtask : t_pin_reset
	// software reset command resets the running module
	task t_sw_reset;
		step(20 * TB_TICK);
		sw_cmd = 1'b1;
		step(10);
		chk(run_b, 1'b0);
		chk(pwr_en, 1'b1);
		sw_cmd = 1'b0;
		step((mpr_pkg::RST_PULSE_MS + 4) * TB_TICK);
		chk(run_b, 1'b1);
	endtask : t_sw_reset
	// power request low turns the module off
	task t_power_off;
		pwr_req = 1'b0;
		step(10);
		chk_off;
	endtask : t_power_off
	// pins released for 250 ms and reset requests while off change nothing
	task t_idle_requests;
		float_pins = 1'b1;
		step(2000);
		chk_off;
		float_pins = 1'b0;
		rst_req = 1'b1;
		step(500);
		rst_req = 1'b0;
		sw_cmd = 1'b1;
		step(50);
		chk_off;
		sw_cmd = 1'b0;
	endtask : t_idle_requests
	initial begin
		rst_b = 1'b0;
		pwr_req = 1'b0;
		rst_req = 1'b0;
		float_pins = 1'b0;
		sw_cmd = 1'b0;
		rf_en = 1'b0;
		step(12);
		rst_b = 1'b1;
		step(1);
		chk_off;
		step(40 * TB_TICK);
		t_short_power;
		t_idle_requests;
		t_power_on;
		t_float_on;
		t_pin_reset;
		t_sw_reset;
		t_power_off;
		close_out;
	end
endmodule : module_power_reset_control_tb_top
